// [hw/cmp_conv_pkg.sv]
// shared constants and types for the comparator and converter control block
package cmp_conv_pkg;

    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_RESULT_LOW = 8'h78;
    localparam logic [7:0] IDX_RESULT_HIGH = 8'h79;
    localparam logic [7:0] IDX_CONV_CTRL_A = 8'h7a;
    localparam logic [7:0] IDX_CONV_CTRL_B = 8'h7b;
    localparam logic [7:0] IDX_CHAN_REF = 8'h7c;
    localparam logic [7:0] IDX_INPUT_DISABLE = 8'h7f;
    localparam logic [7:0] IDX_CMP_CTRL = 8'h50;

    // reset values
    localparam logic [7:0] CONV_CTRL_A_RESET = 8'h00;
    localparam logic [7:0] CONV_CTRL_B_RESET = 8'h00;
    localparam logic [7:0] CHAN_REF_RESET = 8'h00;
    localparam logic [7:0] CMP_CTRL_RESET = 8'h00;
    localparam logic [1:0] INPUT_DISABLE_RESET = 2'h0;

    // writable masks
    localparam logic [7:0] CONV_CTRL_B_WMASK = 8'h47;
    localparam logic [7:0] CMP_CTRL_WMASK = 8'hcf;

    // bit positions
    localparam int CMP_FLAG_BIT = 4;
    localparam int CONV_START_BIT = 6;
    localparam int CONV_FLAG_BIT = 4;
    localparam int PAD_HIGH_BITS = 6;

    // comparator interrupt modes
    typedef enum logic [1:0] {
        MODE_TOGGLE = 2'b00,
        MODE_RESERVED = 2'b01,
        MODE_FALL = 2'b10,
        MODE_RISE = 2'b11
    } cmp_mode_e;

    // conversion timing in converter clock cycles
    localparam int NORMAL_CONV_CYCLES = 13;
    localparam int FIRST_CONV_CYCLES = 25;

    typedef struct packed {
        logic power_off;
        logic bandgap_sel;
        logic out_sync;
        logic irq_flag;
        logic irq_en;
        logic capture_route;
        cmp_mode_e irq_mode;
    } cmp_ctrl_s;

    typedef struct packed {
        logic enable;
        logic start;
        logic auto_trigger_en;
        logic done_flag;
        logic done_irq_en;
        logic [2:0] prescale;
    } conv_ctrl_s;

    typedef struct packed {
        logic [1:0] reference_select;
        logic result_left_align;
        logic spare;
        logic [3:0] channel_select;
    } chan_ref_s;

    // prescaler terminal count: divide by two to the power of the setting, at least two
    function automatic logic [7:0] presc_last(input logic [2:0] ps);
        logic [7:0] div;
        div = (ps == 3'h0) ? 8'h02 : (8'h01 << ps);
        return div - 8'h01;
    endfunction : presc_last

endpackage : cmp_conv_pkg

// [hw/sync2.sv]
// two-stage synchroniser for levels from outside the clock domain
`timescale 1ns/10ps
module sync2 #(
    parameter int W = 1
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    // data
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    logic [W-1:0] meta_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_reg <= '0;
            sync_out <= '0;
        end else if (ce) begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end
endmodule : sync2

// [hw/conv_sequencer.sv]
// converter prescaler and conversion sequencer
`timescale 1ns/10ps
module conv_sequencer
    import cmp_conv_pkg::*;
#(
    parameter int NORMAL = NORMAL_CONV_CYCLES,
    parameter int FIRST = FIRST_CONV_CYCLES
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    // control
    input wire logic enable,
    input wire logic [2:0] prescale,
    input wire logic start,
    input wire logic presc_clear,
    // status
    output logic armed_or_busy,
    output logic converting,
    output logic capture,
    output logic done
);
    typedef enum logic [1:0] {
        IDLE = 2'b00,
        ARMED = 2'b01,
        CONVERT = 2'b10
    } seq_state_e;

    seq_state_e state_reg;
    logic [7:0] presc_reg;
    logic [4:0] count_reg;
    logic first_reg;
    logic tick;
    logic last;

    assign tick = (presc_reg == presc_last(prescale));
    assign last = (count_reg == (first_reg ? 5'(FIRST - 1) : 5'(NORMAL - 1)));
    assign armed_or_busy = (state_reg != IDLE);
    assign converting = (state_reg == CONVERT);
    assign capture = (state_reg == ARMED) && tick && !presc_clear;

    // prescaler held cleared while disabled, restarted by a trigger
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            presc_reg <= 8'h00;
        end else if (ce) begin
            if (!enable || presc_clear || tick) begin
                presc_reg <= 8'h00;
            end else begin
                presc_reg <= presc_reg + 8'h01;
            end
        end
    end

    // 25 ticks for the first conversion after enable, 13 after
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= IDLE;
            count_reg <= 5'h00;
            first_reg <= 1'b1;
            done <= 1'b0;
        end else if (ce) begin
            done <= 1'b0;
            if (!enable) begin
                state_reg <= IDLE;
                first_reg <= 1'b1;
            end else begin
                unique case (state_reg)
                    IDLE: begin
                        if (start) begin
                            state_reg <= ARMED;
                        end
                    end
                    ARMED: begin
                        if (capture) begin
                            state_reg <= CONVERT;
                            count_reg <= 5'h00;
                        end
                    end
                    CONVERT: begin
                        if (tick && last) begin
                            done <= 1'b1;
                            first_reg <= 1'b0;
                            state_reg <= start ? ARMED : IDLE;
                        end else if (tick) begin
                            count_reg <= count_reg + 5'h01;
                        end
                    end
                    default: begin
                        state_reg <= IDLE;
                    end
                endcase
            end
        end
    end

    a_count_bounded: assert property (@(posedge pclk) disable iff (!presetn)
        converting |-> count_reg < 5'(FIRST)) else $error("conversion count overran");
    a_done_ends_run: assert property (@(posedge pclk) disable iff (!presetn)
        done |-> $past(converting)) else $error("done without a conversion");
endmodule : conv_sequencer

// [hw/cmp_conv_ctrl.sv]
// comparator and converter control logic with its apb register file
`timescale 1ns/10ps
module cmp_conv_ctrl
    import cmp_conv_pkg::*;
#(
    parameter int TRIG_W = 8,
    parameter logic [2:0] TRIG_SELF_CODE = 3'h0
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // system side
    input wire logic global_irq_en,
    input wire logic converter_power_reduce,
    input wire logic cmp_irq_ack,
    input wire logic conv_irq_ack,
    output logic cmp_irq,
    output logic conv_irq,
    // analogue model and pins
    input wire logic cmp_raw,
    input wire logic [9:0] conv_result,
    input wire logic [TRIG_W-1:0] trig_in,
    input wire logic [1:0] pin_in,
    output logic [1:0] pin_read,
    // analogue control
    output logic cmp_power_off,
    output logic cmp_bandgap_sel,
    output logic cmp_neg_from_mux,
    output logic [2:0] cmp_neg_channel,
    output logic [3:0] conv_channel,
    output logic [1:0] conv_reference,
    output logic capture_in,
    output logic pos_pin_buf_off,
    output logic neg_pin_buf_off,
    output logic conv_sample
);
    cmp_ctrl_s cmp_reg;
    conv_ctrl_s conv_a_reg;
    chan_ref_s chan_ref_reg;
    logic [7:0] conv_b_reg;
    logic [1:0] in_dis_reg;
    logic [9:0] result_reg;
    logic result_lock_reg;
    logic cmp_prev_reg;
    logic trig_prev_reg;
    logic pready_reg;
    logic [31:0] prdata_reg;
    logic pslverr_reg;
    logic cmp_sync;
    logic [TRIG_W-1:0] trig_sync;
    logic [1:0] pin_sync;
    logic [9:0] result_sync;
    logic conv_en;
    logic access;
    logic fire;
    logic wr;
    logic [7:0] idx;
    logic [7:0] wbyte;
    logic [7:0] rbyte;
    logic mapped;
    logic cmp_event;
    logic trig_level;
    logic trig_edge;
    logic self_src;
    logic seq_active;
    logic seq_conv;
    logic seq_capture;
    logic seq_done;
    logic sw_start;
    logic auto_start;
    logic start_any;

    // analogue model outputs and pins cross in through two flops
    sync2 #(.W(1)) u_cmp_sync (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .async_in(cmp_raw),
        .sync_out(cmp_sync)
    );
    sync2 #(.W(TRIG_W + 12)) u_misc_sync (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .async_in({trig_in, pin_in, conv_result}),
        .sync_out({trig_sync, pin_sync, result_sync})
    );

    // apb decode; one wait state so read data comes from a flop
    assign idx = paddr[9:2];
    assign access = psel && penable;
    assign fire = access && pready_reg;
    assign wr = fire && pwrite;
    assign wbyte = pwdata[7:0];
    assign mapped = (paddr[1:0] == 2'b00) && (paddr[11:10] == 2'b00) &&
                    (idx inside {IDX_RESULT_LOW, IDX_RESULT_HIGH, IDX_CONV_CTRL_A,
                                 IDX_CONV_CTRL_B, IDX_CHAN_REF, IDX_INPUT_DISABLE,
                                 IDX_CMP_CTRL});
    assign pready = pready_reg;
    assign prdata = prdata_reg;
    assign pslverr = pslverr_reg;

    // power reduction forces the converter off until software lifts it
    assign conv_en = conv_a_reg.enable && !converter_power_reduce;

    // read view, alignment applied on the way out
    always_comb begin
        rbyte = 8'h00;
        unique case (idx)
            IDX_RESULT_LOW: begin
                rbyte = chan_ref_reg.result_left_align ? {result_reg[1:0], 6'h00}
                                                       : result_reg[7:0];
            end
            IDX_RESULT_HIGH: begin
                rbyte = chan_ref_reg.result_left_align ? result_reg[9:2]
                                                       : {6'h00, result_reg[9:8]};
            end
            IDX_CONV_CTRL_A: begin
                rbyte = conv_a_reg;
                rbyte[CONV_START_BIT] = seq_active;
            end
            IDX_CONV_CTRL_B: rbyte = conv_b_reg;
            IDX_CHAN_REF: rbyte = chan_ref_reg;
            IDX_INPUT_DISABLE: rbyte = {6'h00, in_dis_reg};
            IDX_CMP_CTRL: begin
                rbyte = cmp_reg;
                rbyte[5] = cmp_sync;
            end
            default: rbyte = 8'h00;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_reg <= 1'b0;
            prdata_reg <= 32'h0000_0000;
            pslverr_reg <= 1'b0;
        end else if (ce) begin
            pready_reg <= access && !pready_reg;
            if (access && !pready_reg) begin
                prdata_reg <= mapped ? {24'h00_0000, rbyte} : 32'h0000_0000;
                pslverr_reg <= !mapped;
            end else if (fire) begin
                pslverr_reg <= 1'b0;
            end
        end
    end

    // comparator event by mode; reserved code raises nothing
    always_comb begin
        unique case (cmp_reg.irq_mode)
            MODE_TOGGLE: cmp_event = cmp_sync != cmp_prev_reg;
            MODE_FALL: cmp_event = cmp_prev_reg && !cmp_sync;
            MODE_RISE: cmp_event = !cmp_prev_reg && cmp_sync;
            MODE_RESERVED: cmp_event = 1'b0;
        endcase
    end

    // comparator control; software must mask the interrupt first
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmp_reg <= CMP_CTRL_RESET;
            cmp_prev_reg <= 1'b0;
        end else if (ce) begin
            cmp_prev_reg <= cmp_sync;
            if (wr && idx == IDX_CMP_CTRL) begin
                cmp_reg <= (cmp_reg & ~CMP_CTRL_WMASK) | (wbyte & CMP_CTRL_WMASK);
            end
            // set beats a simultaneous clear
            if (cmp_event) begin
                cmp_reg.irq_flag <= 1'b1;
            end else if (cmp_irq_ack || (wr && idx == IDX_CMP_CTRL && wbyte[CMP_FLAG_BIT])) begin
                cmp_reg.irq_flag <= 1'b0;
            end
        end
    end

    assign cmp_power_off = cmp_reg.power_off;
    assign cmp_bandgap_sel = cmp_reg.bandgap_sel;
    assign cmp_irq = cmp_reg.irq_flag && cmp_reg.irq_en && global_irq_en;
    assign capture_in = cmp_reg.capture_route && cmp_sync;
    // comparator polarity (positive above negative) is the model's; passed as is
    assign cmp_neg_from_mux = conv_b_reg[6] && !conv_en;
    assign cmp_neg_channel = chan_ref_reg.channel_select[2:0];

    // digital input buffers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            in_dis_reg <= INPUT_DISABLE_RESET;
        end else if (ce && wr && idx == IDX_INPUT_DISABLE) begin
            in_dis_reg <= wbyte[1:0];
        end
    end

    assign pos_pin_buf_off = in_dis_reg[0];
    assign neg_pin_buf_off = in_dis_reg[1];
    assign pin_read = pin_sync & ~in_dis_reg;

    // trigger selection; one code selects our own done flag
    assign self_src = (conv_b_reg[2:0] == TRIG_SELF_CODE);
    assign trig_level = self_src ? conv_a_reg.done_flag : trig_sync[conv_b_reg[2:0]];
    assign trig_edge = trig_level && !trig_prev_reg;

    // edges while busy ignored, a held level never restarts
    assign auto_start = conv_a_reg.auto_trigger_en && conv_en &&
                        ((trig_edge && !seq_active) || (self_src && seq_done));
    assign sw_start = wr && idx == IDX_CONV_CTRL_A && wbyte[CONV_START_BIT] && conv_en;
    assign start_any = sw_start || auto_start;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            trig_prev_reg <= 1'b0;
        end else if (ce) begin
            trig_prev_reg <= trig_level;
        end
    end

    conv_sequencer u_seq (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .enable(conv_en),
        .prescale(conv_a_reg.prescale),
        .start(start_any),
        .presc_clear(auto_start),
        .armed_or_busy(seq_active),
        .converting(seq_conv),
        .capture(seq_capture),
        .done(seq_done)
    );

    assign conv_sample = seq_capture;

    // converter control registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            conv_a_reg <= CONV_CTRL_A_RESET;
            conv_b_reg <= CONV_CTRL_B_RESET;
            chan_ref_reg <= CHAN_REF_RESET;
        end else if (ce) begin
            if (wr && idx == IDX_CONV_CTRL_A) begin
                conv_a_reg.enable <= wbyte[7];
                conv_a_reg.auto_trigger_en <= wbyte[5];
                conv_a_reg.done_irq_en <= wbyte[3];
                conv_a_reg.prescale <= wbyte[2:0];
            end
            if (wr && idx == IDX_CONV_CTRL_B) begin
                conv_b_reg <= wbyte & CONV_CTRL_B_WMASK;
            end
            if (wr && idx == IDX_CHAN_REF) begin
                chan_ref_reg <= wbyte;
            end
            // flag set wins over acknowledge or write-one clear
            if (seq_done) begin
                conv_a_reg.done_flag <= 1'b1;
            end else if (conv_irq_ack ||
                         (wr && idx == IDX_CONV_CTRL_A && wbyte[CONV_FLAG_BIT])) begin
                conv_a_reg.done_flag <= 1'b0;
            end
        end
    end

    assign conv_irq = conv_a_reg.done_flag && conv_a_reg.done_irq_en && global_irq_en;

    // live selection follows the buffer only while enabled and not converting
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            conv_channel <= 4'h0;
            conv_reference <= 2'h0;
        end else if (ce && conv_en && !seq_conv) begin
            conv_channel <= chan_ref_reg.channel_select;
            conv_reference <= chan_ref_reg.reference_select;
        end
    end

    // result registers and read lock; a dropped result still flags done
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            result_reg <= 10'h000;
            result_lock_reg <= 1'b0;
        end else if (ce) begin
            if (seq_done && !result_lock_reg) begin
                result_reg <= result_sync;
            end
            if (fire && !pwrite && idx == IDX_RESULT_LOW) begin
                result_lock_reg <= 1'b1;
            end else if (fire && !pwrite && idx == IDX_RESULT_HIGH) begin
                result_lock_reg <= 1'b0;
            end
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_mux_route_off: assert property (cmp_neg_from_mux |-> !conv_en && conv_b_reg[6])
        else $error("mux routed while converter enabled");
    a_cmp_sync_delay: assert property (ce [*3] |-> cmp_sync == $past(cmp_raw, 2))
        else $error("comparator status not two flops behind");
    a_rise_sets_flag: assert property (ce && cmp_reg.irq_mode == MODE_RISE && cmp_sync &&
        !cmp_prev_reg |=> cmp_reg.irq_flag) else $error("rising event did not flag");
    a_reserved_quiet: assert property (ce && cmp_reg.irq_mode == MODE_RESERVED &&
        !cmp_reg.irq_flag && !(wr && idx == IDX_CMP_CTRL) |=> !cmp_reg.irq_flag)
        else $error("reserved mode raised flag");
    a_irq_gated: assert property (cmp_irq |-> cmp_reg.irq_en && global_irq_en)
        else $error("comparator irq without enables");
    a_buf_off_zero: assert property (pos_pin_buf_off |-> !pin_read[0])
        else $error("disabled pin read as one");
    a_lock_holds: assert property (result_lock_reg && seq_done |=> $stable(result_reg))
        else $error("locked result updated");
    a_done_flags: assert property (ce && seq_done |=> conv_a_reg.done_flag)
        else $error("done did not set flag");
    a_chan_locked: assert property (seq_conv && $past(seq_conv) |-> $stable(conv_channel))
        else $error("channel changed mid conversion");
    a_busy_ignores: assert property (seq_conv && !seq_done |-> !auto_start)
        else $error("trigger accepted while converting");

    c_free_run: cover property (seq_done && self_src && conv_a_reg.auto_trigger_en ##1 seq_active);
    c_dropped: cover property (seq_done && result_lock_reg);
    c_cmp_irq: cover property (cmp_irq);
endmodule : cmp_conv_ctrl

// [tb/tb_cmp_conv_ctrl.sv]
// self-checking bench for the comparator and converter control block
`timescale 1ns/10ps
module tb_cmp_conv_ctrl;
    import cmp_conv_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic err;
    logic global_irq_en = 1'b1;
    logic cmp_irq;
    logic conv_irq;
    logic cmp_raw = 1'b0;
    logic [9:0] conv_result = 10'h2a5;
    logic [7:0] trig_in = 8'h00;
    logic power_reduce = 1'b0;
    logic [1:0] pin_in = 2'b11;
    logic [1:0] pin_read;
    logic cmp_neg_from_mux;
    logic [2:0] cmp_neg_channel;
    int miscompares = 0;
    int total_checks = 0;

    always #5 pclk = ~pclk;

    // ce held high and vector acks tied low; power reduce lifted before use
    cmp_conv_ctrl u_cmp_conv_ctrl (.pclk(pclk), .presetn(presetn), .ce(1'b1),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .global_irq_en(global_irq_en),
        .converter_power_reduce(power_reduce), .cmp_irq_ack(1'b0), .conv_irq_ack(1'b0),
        .cmp_irq(cmp_irq), .conv_irq(conv_irq), .cmp_raw(cmp_raw), .conv_result(conv_result),
        .trig_in(trig_in), .pin_in(pin_in), .pin_read(pin_read), .cmp_power_off(),
        .cmp_bandgap_sel(), .cmp_neg_from_mux(cmp_neg_from_mux),
        .cmp_neg_channel(cmp_neg_channel), .conv_channel(), .conv_reference(),
        .capture_in(), .pos_pin_buf_off(), .neg_pin_buf_off(), .conv_sample());

    task automatic end_sim();
        $display("checks %0d miscompares %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : end_sim

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // values read right after the edge are the ones sampled at it
    task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] wd,
                       output logic [7:0] rd);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {2'b00, idx, 2'b00};
        pwdata <= {24'h0, wd};
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata[7:0];
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            miscompares++;
            end_sim();
        end
    endtask : apb

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        logic [7:0] x;
        apb(1'b1, idx, d, x);
        // let the write settle before outputs are looked at
        @(negedge pclk);
    endtask : wr

    task automatic rdc(input logic [7:0] idx, input logic [7:0] exp);
        logic [7:0] v;
        apb(1'b0, idx, 8'h00, v);
        chk(v, exp);
    endtask : rdc

    task automatic t_regs();
        rdc(IDX_CONV_CTRL_B, CONV_CTRL_B_RESET);
        rdc(IDX_CMP_CTRL, CMP_CTRL_RESET);
        rdc(8'h01, 8'h00);
        chk(err, 1'b1);
        wr(IDX_CONV_CTRL_B, 8'hff);
        rdc(IDX_CONV_CTRL_B, 8'h47);
        wr(IDX_CHAN_REF, 8'h05);
        chk(cmp_neg_from_mux, 1'b1);
        chk(cmp_neg_channel, 3'h5);
        power_reduce <= 1'b1;
        wr(IDX_CONV_CTRL_A, 8'h80);
        chk(cmp_neg_from_mux, 1'b1);
        power_reduce <= 1'b0;
        @(negedge pclk);
        chk(cmp_neg_from_mux, 1'b0);
        wr(IDX_CONV_CTRL_A, 8'h00);
    endtask : t_regs

    task automatic t_cmp();
        wr(IDX_CMP_CTRL, 8'h0b);
        cmp_raw <= 1'b1;
        repeat (4) @(posedge pclk);
        chk(cmp_irq, 1'b1);
        rdc(IDX_CMP_CTRL, 8'h3b);
        global_irq_en <= 1'b0;
        @(posedge pclk);
        chk(cmp_irq, 1'b0);
        global_irq_en <= 1'b1;
        wr(IDX_CMP_CTRL, 8'h1b);
        rdc(IDX_CMP_CTRL, 8'h2b);
        // falling edge must not flag in rising mode
        cmp_raw <= 1'b0;
        repeat (4) @(posedge pclk);
        rdc(IDX_CMP_CTRL, 8'h0b);
        wr(IDX_CMP_CTRL, 8'h03);
        wr(IDX_CMP_CTRL, 8'h02);
        cmp_raw <= 1'b1;
        repeat (4) @(posedge pclk);
        rdc(IDX_CMP_CTRL, 8'h22);
    endtask : t_cmp

    task automatic t_pins();
        wr(IDX_INPUT_DISABLE, 8'hfd);
        rdc(IDX_INPUT_DISABLE, 8'h01);
        repeat (3) @(posedge pclk);
        chk(pin_read, 2'b10);
    endtask : t_pins

    task automatic conv_wait(input logic [7:0] exp);
        logic [7:0] v;
        int n;
        apb(1'b0, IDX_CONV_CTRL_A, 8'h00, v);
        chk(v[CONV_START_BIT], 1'b1);
        n = 0;
        while (v[CONV_START_BIT] !== 1'b0 && n < 200) begin
            apb(1'b0, IDX_CONV_CTRL_A, 8'h00, v);
            n++;
        end
        chk(v, exp);
        if (n >= 200) end_sim();
    endtask : conv_wait

    task automatic t_conv();
        wr(IDX_CHAN_REF, 8'h00);
        wr(IDX_CONV_CTRL_A, 8'h80);
        wr(IDX_CONV_CTRL_A, 8'hc0);
        conv_wait(8'h90);
        rdc(IDX_RESULT_LOW, 8'ha5);
        // second result lands while the bytes are locked
        conv_result <= 10'h15a;
        wr(IDX_CONV_CTRL_A, 8'hd0);
        conv_wait(8'h90);
        rdc(IDX_RESULT_HIGH, 8'h02);
        wr(IDX_CONV_CTRL_A, 8'hd0);
        conv_wait(8'h90);
        rdc(IDX_RESULT_LOW, 8'h5a);
        rdc(IDX_RESULT_HIGH, 8'h01);
    endtask : t_conv

    task automatic t_auto();
        wr(IDX_CONV_CTRL_B, 8'h01);
        wr(IDX_CONV_CTRL_A, 8'hb0);
        trig_in <= 8'h02;
        // trigger crosses two flops before its edge is seen
        repeat (4) @(posedge pclk);
        conv_wait(8'hb0);
        rdc(IDX_CONV_CTRL_A, 8'hb0);
        trig_in <= 8'h00;
        wr(IDX_CONV_CTRL_B, 8'h00);
        wr(IDX_CONV_CTRL_A, 8'he0);
        repeat (80) @(posedge pclk);
        rdc(IDX_CONV_CTRL_A, 8'hf0);
        wr(IDX_CONV_CTRL_A, 8'h00);
    endtask : t_auto

    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_cmp();
        t_pins();
        t_conv();
        t_auto();
        end_sim();
    end
endmodule : tb_cmp_conv_ctrl
